// ==== src/bsc_slave.v ====
// Purpose: command decoder of a daisy-chained bus slave node
// Assumes: a framer delivers whole received frames with a valid pulse
// Notes: replies are staged here and sent by the framer next message
`include "bsc_consts.vh"

module bsc_slave #(
    parameter ADC_TIMEOUT = 16'd1000,
    parameter [3:0] CRC_POLY = 4'h3
) (
    input wire SYS_CLK,
    input wire RST,
    input wire RX_VALID,
    input wire RX_LONG,
    input wire [19:0] RX_FRAME,
    input wire MSG_START,
    input wire UV_PIN,
    input wire BUS_SHORT_PIN,
    input wire [3:0] IO_PIN,
    input wire LOGIC_OUTPUT_PIN,
    input wire CONV_DONE,
    input wire CONV_FAIL,
    input wire [7:0] CONV_DATA,
    output reg TX_VALID,
    output reg TX_LONG,
    output reg [19:0] TX_FRAME,
    output wire BUS_SWITCH_CLOSED,
    output wire NODE_ACTIVE,
    output wire [3:0] NODE_ADDRESS,
    output wire NONVOLATILE_WRITE_FLAG,
    output wire CONV_START,
    output wire [1:0] CONV_SEL
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    reg [2:0] meta_r; // first stage, read only by second
    reg [2:0] sync_r; // second stage
    reg [3:0] io_meta_r; // io first stage
    reg [3:0] io_sync_r; // io second stage
    wire uv_s; // undervoltage level
    wire short_s; // bus out short to battery
    wire logic_out_s; // logic output driven level

    assign uv_s = sync_r[0];
    assign short_s = sync_r[1];
    assign logic_out_s = sync_r[2];

    // two flops per asynchronous pin
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            meta_r <= 3'b000;
            sync_r <= 3'b000;
            io_meta_r <= 4'h0;
            io_sync_r <= 4'h0;
        end else begin
            meta_r <= {LOGIC_OUTPUT_PIN, BUS_SHORT_PIN, UV_PIN};
            sync_r <= meta_r;
            io_meta_r <= IO_PIN;
            io_sync_r <= io_meta_r;
        end
    end

    // ----------------------------------------------------------------
    // frame fields
    // ----------------------------------------------------------------
    wire [7:0] f_data; // data byte
    wire [3:0] f_addr; // destination address
    wire [3:0] f_cmd; // command code
    wire [3:0] f_crc; // received crc
    wire [3:0] rx_crc_calc; // recomputed crc
    wire crc_ok; // frame passes crc

    assign f_data = RX_FRAME[`BSC_F_DATA_HI:`BSC_F_DATA_LO];
    assign f_addr = RX_FRAME[`BSC_F_ADDR_HI:`BSC_F_ADDR_LO];
    assign f_cmd = RX_FRAME[`BSC_F_CMD_HI:`BSC_F_CMD_LO];
    assign f_crc = RX_FRAME[`BSC_F_CRC_HI:`BSC_F_CRC_LO];

    // crc over data, address and command of the received frame
    bsc_crc4 #(
        .WIDTH(16),
        .POLY(CRC_POLY)
    ) u_rx_crc (
        .data_in(RX_FRAME[19:4]),
        .crc_out(rx_crc_calc)
    );

    assign crc_ok = (rx_crc_calc == f_crc);

    // ----------------------------------------------------------------
    // node state
    // ----------------------------------------------------------------
    reg init_done_r; // initialization accepted
    reg [3:0] addr_r; // assigned node address
    reg [1:0] group_r; // group bits, stored and echoed in the init reply
    reg nvwrite_r; // nonvolatile write flag
    reg sw_closed_r; // bus switch closed
    reg fault_r; // bus fault seen at init
    reg uv_cmd_r; // undervoltage since last frame
    reg [3:0] pend_cmd_r; // reply kind pending
    reg pend_r; // reply pending
    reg pend_long_r; // reply size

    // ----------------------------------------------------------------
    // command decode
    // ----------------------------------------------------------------
    wire is_init; // init command
    wire is_value; // value query
    wire is_query; // status or value
    wire addr_hit; // addressed to this node
    wire init_take; // init accepted
    reg [1:0] val_sel; // converter channel

    assign is_init = (f_cmd == `BSC_CMD_INIT);
    assign is_value = (f_cmd == `BSC_CMD_VAL0) || (f_cmd == `BSC_CMD_VAL1) ||
        (f_cmd == `BSC_CMD_VAL2) || (f_cmd == `BSC_CMD_VAL3);
    assign is_query = is_value || (f_cmd == `BSC_CMD_STATUS);
    // zero address never matches a query
    assign addr_hit = init_done_r && (f_addr == addr_r) &&
        (f_addr != `BSC_ADDR_ZERO);
    // init: first open-switch node at address zero, or own programmed address
    assign init_take = RX_VALID && crc_ok && RX_LONG && is_init && !init_done_r &&
        !sw_closed_r && ((f_addr == `BSC_ADDR_ZERO) || (f_addr == addr_r));

    // command code to converter channel
    always @* begin
        case (f_cmd)
            `BSC_CMD_VAL1: val_sel = 2'd1;
            `BSC_CMD_VAL2: val_sel = 2'd2;
            `BSC_CMD_VAL3: val_sel = 2'd3;
            default: val_sel = 2'd0;
        endcase
    end

    wire adc_start; // value query accepted
    wire [7:0] adc_result; // measurement

    assign adc_start = RX_VALID && crc_ok && addr_hit && is_value;

    bsc_adc_ctl #(
        .TIMEOUT(ADC_TIMEOUT)
    ) u_adc (
        .clk(SYS_CLK),
        .rst(RST),
        .start(adc_start),
        .sel(val_sel),
        .uv_seen(uv_cmd_r | uv_s),
        .conv_done(CONV_DONE),
        .conv_fail(CONV_FAIL),
        .conv_data(CONV_DATA),
        .conv_start_r(CONV_START),
        .conv_sel_r(CONV_SEL),
        .result_r(adc_result),
        .busy_r()
    );

    // ----------------------------------------------------------------
    // state update on each received frame
    // ----------------------------------------------------------------
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            init_done_r <= 1'b0;
            addr_r <= `BSC_ADDR_RESET;
            group_r <= 2'b00;
            nvwrite_r <= 1'b0;
            sw_closed_r <= 1'b0;
            fault_r <= 1'b0;
            uv_cmd_r <= 1'b0;
            pend_r <= 1'b0;
            pend_long_r <= 1'b0;
            pend_cmd_r <= 4'h0;
        end else begin
            // undervoltage tracked across the command window
            if (RX_VALID) begin
                uv_cmd_r <= uv_s;
            end else if (uv_s) begin
                uv_cmd_r <= 1'b1;
            end
            // pending reply is consumed at next message start
            if (MSG_START) begin
                pend_r <= 1'b0;
            end
            if (init_take) begin
                addr_r <= f_data[3:0];
                group_r <= f_data[`BSC_D_GRP_HI:`BSC_D_GRP_LO];
                nvwrite_r <= f_data[`BSC_D_NVWRITE];
                sw_closed_r <= f_data[`BSC_D_SWITCH] && !short_s;
                fault_r <= short_s;
                init_done_r <= 1'b1;
                pend_r <= 1'b1;
                pend_long_r <= 1'b1;
                pend_cmd_r <= `BSC_CMD_INIT;
            end else if (RX_VALID && crc_ok && f_cmd == `BSC_CMD_CLEAR &&
                    (addr_hit || f_addr == `BSC_ADDR_ZERO)) begin
                // clear: back to reset values, switch open, no reply
                init_done_r <= 1'b0;
                addr_r <= `BSC_ADDR_RESET;
                group_r <= 2'b00;
                nvwrite_r <= 1'b0;
                sw_closed_r <= 1'b0;
                fault_r <= 1'b0;
                pend_r <= 1'b0;
            end else if (RX_VALID && crc_ok && addr_hit && is_query) begin
                pend_r <= 1'b1;
                pend_long_r <= RX_LONG;
                pend_cmd_r <= f_cmd;
            end
        end
    end

    // ----------------------------------------------------------------
    // reply assembly
    // ----------------------------------------------------------------
    reg [7:0] hi_byte; // address byte
    reg [7:0] lo_byte; // payload byte
    wire [3:0] tx_crc_long; // crc of 16 bits
    wire [3:0] tx_crc_short; // crc of 8 bits

    // payload by pending command
    always @* begin
        hi_byte = {addr_r, 4'h0};
        case (pend_cmd_r)
            `BSC_CMD_INIT: begin
                hi_byte = {addr_r, 3'b000, fault_r};
                lo_byte = {nvwrite_r, sw_closed_r, group_r, addr_r};
            end
            `BSC_CMD_STATUS: begin
                lo_byte = {nvwrite_r, uv_s, logic_out_s, sw_closed_r, io_sync_r};
            end
            default: begin
                lo_byte = adc_result;
            end
        endcase
    end

    bsc_crc4 #(
        .WIDTH(16),
        .POLY(CRC_POLY)
    ) u_tx_crc_l (
        .data_in({hi_byte, lo_byte}),
        .crc_out(tx_crc_long)
    );

    bsc_crc4 #(
        .WIDTH(8),
        .POLY(CRC_POLY)
    ) u_tx_crc_s (
        .data_in(lo_byte),
        .crc_out(tx_crc_short)
    );

    // drive reply at the start of the following message
    always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            TX_VALID <= 1'b0;
            TX_LONG <= 1'b0;
            TX_FRAME <= 20'h00000;
        end else begin
            TX_VALID <= 1'b0;
            if (MSG_START && pend_r) begin
                TX_VALID <= 1'b1;
                TX_LONG <= pend_long_r;
                if (pend_long_r) begin
                    TX_FRAME <= {hi_byte, lo_byte, tx_crc_long};
                end else begin
                    // short reply omits the high byte
                    TX_FRAME <= {8'h00, lo_byte, tx_crc_short};
                end
            end
        end
    end

    assign BUS_SWITCH_CLOSED = sw_closed_r;
    assign NODE_ACTIVE = init_done_r;
    assign NODE_ADDRESS = addr_r;
    assign NONVOLATILE_WRITE_FLAG = nvwrite_r;
endmodule

// ==== src/bsc_consts.vh ====
// Purpose: constants for the bus slave command decoder
// Assumes: 20-bit long-word frames, 8-bit short words, 10 MHz system clock
// Notes: every command code and frame field position lives here, with the address reset value
//
// Summary of operation
// - no traffic before initialization is accepted
// - first open-switch node takes address-zero init
// - nonvolatile flag recorded, address still assigned
// - further inits ignored until clear or reset
// - switch closes if requested and no fault
// - init frame: flags, group, address, command, CRC
// - init reply long word only, next message
// - init reply: address, zeros, fault, fields, CRC
// - bus fault flag reports downstream short
// - status reports flags, switch, output, pins
// - queries to address zero are ignored
// - query reply: address byte, payload, CRC
// - status byte: flags, output, switch, pins
// - undervoltage flag reads one while present
// - value query measures one I/O line
// - command code selects converter input
// - conversion in idle, sampled at command end
// - undervoltage or failure returns zero
// - value reply carries measurement low byte
// - reply size matches command size, next message
// - clear opens switch and resets registers
`ifndef BSC_CONSTS_VH
`define BSC_CONSTS_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define BSC_CMD_INIT 4'h0
`define BSC_CMD_STATUS 4'h1
`define BSC_CMD_VAL0 4'h2
`define BSC_CMD_VAL1 4'h5
`define BSC_CMD_VAL2 4'h6
`define BSC_CMD_CLEAR 4'h7
`define BSC_CMD_VAL3 4'h8

// ----------------------------------------------------------------
// frame field positions (bit 19 is sent first)
// ----------------------------------------------------------------
`define BSC_F_DATA_HI 19
`define BSC_F_DATA_LO 12
`define BSC_F_ADDR_HI 11
`define BSC_F_ADDR_LO 8
`define BSC_F_CMD_HI 7
`define BSC_F_CMD_LO 4
`define BSC_F_CRC_HI 3
`define BSC_F_CRC_LO 0
`define BSC_D_NVWRITE 7
`define BSC_D_SWITCH 6
`define BSC_D_GRP_HI 5
`define BSC_D_GRP_LO 4

// ----------------------------------------------------------------
// reset values and misc
// ----------------------------------------------------------------
`define BSC_ADDR_RESET 4'h0
`define BSC_ADDR_ZERO 4'h0
`define BSC_CRC_SEED 4'h0
`define BSC_ADC_ERROR 8'h00
`define BSC_ADC_MIN 8'h01

`endif

// ==== src/bsc_crc4.v ====
// Purpose: 4-bit CRC over a data field, most significant bit first
// Assumes: polynomial is a parameter and seed a shared constant, neither fixed by the bus
// Notes: purely combinational; used for both checking and generating
`include "bsc_consts.vh"

module bsc_crc4 #(
    parameter WIDTH = 16,
    parameter [3:0] POLY = 4'h3
) (
    input wire [WIDTH-1:0] data_in,
    output reg [3:0] crc_out
);
    // ----------------------------------------------------------------
    // serial division unrolled by a loop
    // ----------------------------------------------------------------
    integer i;
    reg fb; // feedback bit
    always @* begin
        fb = 1'b0;
        crc_out = `BSC_CRC_SEED;
        for (i = WIDTH - 1; i >= 0; i = i - 1) begin
            fb = crc_out[3] ^ data_in[i];
            crc_out = {crc_out[2:0], 1'b0} ^ (fb ? POLY : 4'h0);
        end
    end
endmodule

// ==== src/bsc_adc_ctl.v ====
// Purpose: conversion sequencer for a value query
// Assumes: converter answers with a done pulse or an error level
// Notes: result forced to the error code on undervoltage or failure
`include "bsc_consts.vh"

module bsc_adc_ctl #(
    parameter TIMEOUT = 16'd1000
) (
    input wire clk,
    input wire rst,
    input wire start, // command end pulse
    input wire [1:0] sel, // channel chosen
    input wire uv_seen, // undervoltage during command
    input wire conv_done, // converter result ready
    input wire conv_fail, // converter error
    input wire [7:0] conv_data, // converter result
    output reg conv_start_r, // sample/hold pulse
    output reg [1:0] conv_sel_r, // mux select
    output reg [7:0] result_r, // value for reply
    output reg busy_r // conversion in progress
);
    reg [15:0] tmo_r; // timeout counter
    reg uv_r; // undervoltage latched with start

    // ----------------------------------------------------------------
    // sequence: start, wait for done, check error
    // ----------------------------------------------------------------
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_start_r <= 1'b0;
            conv_sel_r <= 2'd0;
            result_r <= `BSC_ADC_ERROR;
            busy_r <= 1'b0;
            tmo_r <= 16'd0;
            uv_r <= 1'b0;
        end else begin
            conv_start_r <= 1'b0;
            if (start) begin
                // sample the input as it stood at command end
                conv_start_r <= 1'b1;
                conv_sel_r <= sel;
                busy_r <= 1'b1;
                tmo_r <= 16'd0;
                uv_r <= uv_seen;
                result_r <= `BSC_ADC_ERROR;
            end else if (busy_r) begin
                tmo_r <= tmo_r + 16'd1;
                if (conv_done) begin
                    busy_r <= 1'b0;
                    // error code on undervoltage or failure; a zero reading becomes the minimum code
                    if (uv_r || conv_fail) begin
                        result_r <= `BSC_ADC_ERROR;
                    end else if (conv_data == `BSC_ADC_ERROR) begin
                        result_r <= `BSC_ADC_MIN;
                    end else begin
                        result_r <= conv_data;
                    end
                end else if (conv_fail || tmo_r == TIMEOUT) begin
                    busy_r <= 1'b0;
                    result_r <= `BSC_ADC_ERROR;
                end
            end
        end
    end
endmodule

// ==== verification/bsc_bus_master.sv ====
// Purpose: bus master stand-in that sends frames and starts messages
// Assumes: crc poly 0x3, seed 0, top bit first, over frame bits 19..4
// Notes: frame lines carry inverted data between frames
module bsc_bus_master (
    input wire clk,
    input wire tx_valid,
    input wire tx_long,
    input wire [19:0] tx_frame,
    output logic rx_valid = 1'b0,
    output logic rx_long = 1'b0,
    output logic [19:0] rx_frame = 20'h0,
    output logic msg_start = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // crc over the low n bits of d, top bit first
    function automatic [3:0] crc(input [15:0] d, input int n);
        logic [3:0] c;
        c = 4'h0;
        for (int i = n - 1; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
        end
        return c;
    endfunction
    // one frame: data, address, command, crc; bad spoils the crc
    task automatic send(input logic lng, input [3:0] a, input [3:0] c, input [7:0] d,
        input logic bad);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_long <= lng;
        rx_frame <= {d, a, c, crc({d, a, c}, 16) ^ {4{bad}}};
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_frame <= ~{d, a, c, 4'h0};
    endtask
    // start a message and catch the one-cycle reply pulse
    task automatic msg(output logic got, output logic [19:0] f, output logic l);
        got = 1'b0;
        f = 20'h0;
        l = 1'b0;
        @(posedge clk);
        msg_start <= 1'b1;
        @(posedge clk);
        msg_start <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            #1;
            if (tx_valid && !got) begin
                got = 1'b1;
                f = tx_frame;
                l = tx_long;
            end
            @(posedge clk);
        end
    endtask
endmodule

// ==== verification/bsc_slave_sva.sv ====
// Purpose: assertion checker for the bus slave command decoder
// Assumes: crc poly 0x3, seed 0, top bit first, over frame bits 19..4
// Notes: bound onto bsc_slave, sees its ports only
`include "bsc_consts.vh"
module bsc_slave_sva (
    input wire SYS_CLK,
    input wire RST,
    input wire RX_VALID,
    input wire RX_LONG,
    input wire [19:0] RX_FRAME,
    input wire MSG_START,
    input wire TX_VALID,
    input wire TX_LONG,
    input wire [19:0] TX_FRAME,
    input wire BUS_SWITCH_CLOSED,
    input wire NODE_ACTIVE,
    input wire [3:0] NODE_ADDRESS,
    input wire NONVOLATILE_WRITE_FLAG,
    input wire CONV_START,
    input wire [1:0] CONV_SEL
);
    // crc of a received header, top bit first
    function automatic [3:0] crc16(input [15:0] d);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            c = {c[2:0], 1'b0} ^ ((c[3] ^ d[i]) ? 4'h3 : 4'h0);
        end
        return c;
    endfunction
    wire [3:0] cmd = RX_FRAME[7:4]; // command field
    wire [3:0] adr = RX_FRAME[11:8]; // address field
    wire ok = RX_VALID && crc16(RX_FRAME[19:4]) == RX_FRAME[3:0]; // good frame
    wire hit = ok && NODE_ACTIVE && adr != 4'h0 && adr == NODE_ADDRESS; // addressed
    wire init_ok = ok && RX_LONG && cmd == `BSC_CMD_INIT && adr == 4'h0
        && !NODE_ACTIVE && !BUS_SWITCH_CLOSED; // init that must be taken
    wire isval = cmd == `BSC_CMD_VAL0 || cmd == `BSC_CMD_VAL1
        || cmd == `BSC_CMD_VAL2 || cmd == `BSC_CMD_VAL3; // value query
    wire [1:0] ch = cmd == `BSC_CMD_VAL0 ? 2'h0 : cmd == `BSC_CMD_VAL1 ? 2'h1
        : cmd == `BSC_CMD_VAL2 ? 2'h2 : 2'h3; // converter channel
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_tx_once; TX_VALID |=> !TX_VALID; endproperty
    a_tx_once: assert property (p_tx_once) else $error("reply pulse too long");
    property p_tx_cause; TX_VALID |-> $past(MSG_START) && NODE_ACTIVE; endproperty
    a_tx_cause: assert property (p_tx_cause) else $error("reply without cause");
    property p_tx_hi; TX_VALID && TX_LONG |-> TX_FRAME[19:13] == {NODE_ADDRESS, 3'h0};
    endproperty
    a_tx_hi: assert property (p_tx_hi) else $error("reply high byte wrong");
    property p_tx_short; TX_VALID && !TX_LONG |-> TX_FRAME[19:12] == 8'h00; endproperty
    a_tx_short: assert property (p_tx_short) else $error("short reply wrong");
    property p_init; init_ok |=> NODE_ACTIVE && NODE_ADDRESS == $past(RX_FRAME[15:12])
        && NONVOLATILE_WRITE_FLAG == $past(RX_FRAME[19]); endproperty
    a_init: assert property (p_init) else $error("init not taken");
    property p_init_once; ok && NODE_ACTIVE && cmd == `BSC_CMD_INIT
        |=> $stable(NODE_ADDRESS) && $stable(NONVOLATILE_WRITE_FLAG); endproperty
    a_init_once: assert property (p_init_once) else $error("second init taken");
    property p_switch; $rose(BUS_SWITCH_CLOSED) |-> $past(init_ok) && $past(RX_FRAME[18]);
    endproperty
    a_switch: assert property (p_switch) else $error("switch closed unasked");
    property p_zero_q; ok && adr == 4'h0 && isval |=> !CONV_START [*3]; endproperty
    a_zero_q: assert property (p_zero_q) else $error("query to zero acted on");
    property p_conv; hit && isval |=> CONV_START && CONV_SEL == $past(ch); endproperty
    a_conv: assert property (p_conv) else $error("conversion not started");
    property p_bad; RX_VALID && !ok |=> $stable(NODE_ACTIVE) && !CONV_START; endproperty
    a_bad: assert property (p_bad) else $error("bad frame acted on");
    property p_clear; ok && cmd == `BSC_CMD_CLEAR && (adr == 4'h0 || hit)
        |=> !NODE_ACTIVE && !BUS_SWITCH_CLOSED; endproperty
    a_clear: assert property (p_clear) else $error("clear not done");
    c_init: cover property (init_ok);
    c_short: cover property (TX_VALID && !TX_LONG);
    c_conv: cover property (CONV_START);
endmodule
bind bsc_slave bsc_slave_sva u_sva (.SYS_CLK(SYS_CLK), .RST(RST), .RX_VALID(RX_VALID),
    .RX_LONG(RX_LONG), .RX_FRAME(RX_FRAME), .MSG_START(MSG_START), .TX_VALID(TX_VALID),
    .TX_LONG(TX_LONG), .TX_FRAME(TX_FRAME), .BUS_SWITCH_CLOSED(BUS_SWITCH_CLOSED),
    .NODE_ACTIVE(NODE_ACTIVE), .NODE_ADDRESS(NODE_ADDRESS),
    .NONVOLATILE_WRITE_FLAG(NONVOLATILE_WRITE_FLAG), .CONV_START(CONV_START),
    .CONV_SEL(CONV_SEL));

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the bus slave command decoder
// Assumes: replies carry the master-side crc; converter answers in 4 cycles
// Notes: table rows first, then zero reading, faults, clear and reset
`define CHK(nm, e, g) \
    num_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("unexpected %s exp %h got %h", nm, e, g); \
    end
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic lng; logic [3:0] a; logic [3:0] c; logic [7:0] d;
        logic bad; logic rv; logic [7:0] lo;
    } bsc_row_t;
    logic sys_clk = 1'b0, rst = 1'b1, uv = 1'b0, short_pin = 1'b0, fault = 1'b0;
    logic logic_out = 1'b1;
    logic [3:0] io_pins = 4'ha;
    logic cdone = 1'b0, cfail = 1'b0, conv_bad = 1'b0;
    logic [7:0] cdata = 8'h00, conv_val = 8'h40;
    logic [2:0] cd_r = 3'h0;
    logic [3:0] node = 4'h5;
    int n_errors = 0, num_checks = 0;
    wire rx_valid, rx_long, msg_start, tx_valid, tx_long, sw, active, nvf, conv_start;
    wire [19:0] rx_frame, tx_frame;
    wire [3:0] node_address;
    wire [1:0] conv_sel;
    // ordinary traffic: node at address 5, io pins 4'ha, logic output high
    bsc_row_t rows [14] = '{
        '{1'b1, 4'h5, 4'h0, 8'h05, 1'b0, 1'b0, 8'h00},
        '{1'b1, 4'h0, 4'h0, 8'h45, 1'b0, 1'b1, 8'h45},
        '{1'b0, 4'h5, 4'h1, 8'h00, 1'b0, 1'b1, 8'h3a},
        '{1'b1, 4'h5, 4'h1, 8'h00, 1'b0, 1'b1, 8'h3a},
        '{1'b0, 4'h5, 4'h2, 8'h00, 1'b0, 1'b1, 8'h40},
        '{1'b1, 4'h5, 4'h5, 8'h00, 1'b0, 1'b1, 8'h41},
        '{1'b0, 4'h5, 4'h6, 8'h00, 1'b0, 1'b1, 8'h42},
        '{1'b1, 4'h5, 4'h8, 8'h00, 1'b0, 1'b1, 8'h43},
        '{1'b0, 4'h0, 4'h1, 8'h00, 1'b0, 1'b0, 8'h00},
        '{1'b0, 4'h0, 4'h5, 8'h00, 1'b0, 1'b0, 8'h00},
        '{1'b0, 4'h3, 4'h1, 8'h00, 1'b0, 1'b0, 8'h00},
        '{1'b1, 4'h0, 4'h0, 8'h47, 1'b0, 1'b0, 8'h00},
        '{1'b0, 4'h5, 4'h1, 8'h00, 1'b1, 1'b0, 8'h00},
        '{1'b0, 4'h5, 4'h3, 8'h00, 1'b0, 1'b0, 8'h00}};
    always #50 sys_clk = ~sys_clk;
    bsc_bus_master m (.clk(sys_clk), .tx_valid(tx_valid), .tx_long(tx_long),
        .tx_frame(tx_frame), .rx_valid(rx_valid), .rx_long(rx_long),
        .rx_frame(rx_frame), .msg_start(msg_start));
    bsc_slave #(.ADC_TIMEOUT(16'd20)) uut (.SYS_CLK(sys_clk), .RST(rst),
        .RX_VALID(rx_valid), .RX_LONG(rx_long), .RX_FRAME(rx_frame),
        .MSG_START(msg_start), .UV_PIN(uv), .BUS_SHORT_PIN(short_pin), .IO_PIN(io_pins),
        .LOGIC_OUTPUT_PIN(logic_out), .CONV_DONE(cdone), .CONV_FAIL(cfail), .CONV_DATA(cdata),
        .TX_VALID(tx_valid), .TX_LONG(tx_long), .TX_FRAME(tx_frame),
        .BUS_SWITCH_CLOSED(sw), .NODE_ACTIVE(active), .NODE_ADDRESS(node_address),
        .NONVOLATILE_WRITE_FLAG(nvf), .CONV_START(conv_start), .CONV_SEL(conv_sel));
    // converter stand-in: result or failure four cycles after a start
    always @(posedge sys_clk) begin
        cd_r <= {cd_r[1:0], conv_start};
        cdone <= cd_r[2] && !conv_bad;
        cfail <= cd_r[2] && conv_bad;
        cdata <= cd_r[2] ? conv_val + {6'h0, conv_sel} : ~cdata;
    end
    // expected reply frame from its high and low bytes
    function automatic [19:0] xf(input logic lng, input [7:0] hi, input [7:0] lo);
        return lng ? {hi, lo, m.crc({hi, lo}, 16)} : {8'h00, lo, m.crc({8'h00, lo}, 8)};
    endfunction
    // one command, an idle gap, then the next message and its reply
    task automatic run(input bsc_row_t r);
        logic got, l;
        logic [19:0] f;
        logic [7:0] hi;
        hi = {node, 3'h0, fault && r.c == 4'h0};
        m.send(r.lng, r.a, r.c, r.d, r.bad);
        repeat (8) @(posedge sys_clk);
        m.msg(got, f, l);
        `CHK("reply", r.rv, got)
        if (r.rv) begin
            `CHK("frame", xf(r.lng, hi, r.lo), f)
            `CHK("size", r.lng, l)
        end
    endtask
    // closing report
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        `CHK("reset", 27'h0, {tx_valid, active, sw, node_address, tx_frame})
        rst <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            run(rows[i]);
        end
        `CHK("address", 4'h5, node_address)
        `CHK("switch", 1'b1, sw)
        conv_val <= 8'h00;
        run('{1'b0, 4'h5, 4'h2, 8'h00, 1'b0, 1'b1, 8'h01});
        conv_bad <= 1'b1;
        run('{1'b1, 4'h5, 4'h6, 8'h00, 1'b0, 1'b1, 8'h00});
        conv_bad <= 1'b0;
        uv <= 1'b1;
        logic_out <= 1'b0;
        io_pins <= 4'h5;
        // pins need two edges through the synchronisers
        repeat (2) @(posedge sys_clk);
        run('{1'b0, 4'h5, 4'h5, 8'h00, 1'b0, 1'b1, 8'h00});
        run('{1'b0, 4'h5, 4'h1, 8'h00, 1'b0, 1'b1, 8'h55});
        uv <= 1'b0;
        short_pin <= 1'b1;
        run('{1'b0, 4'h5, 4'h7, 8'h00, 1'b0, 1'b0, 8'h00});
        `CHK("cleared", 2'h0, {active, sw})
        run('{1'b0, 4'h0, 4'h0, 8'hc9, 1'b0, 1'b0, 8'h00});
        `CHK("short init", 1'b0, active)
        node = 4'h9;
        fault = 1'b1;
        run('{1'b1, 4'h0, 4'h0, 8'hc9, 1'b0, 1'b1, 8'h89});
        `CHK("fault init", 7'h59, {active, sw, nvf, node_address})
        rst <= 1'b1;
        @(posedge sys_clk);
        #1;
        `CHK("rerun reset", 4'h0, {active, sw, nvf, tx_valid})
        rst <= 1'b0;
        short_pin <= 1'b0;
        node = 4'h5;
        fault = 1'b0;
        run(rows[1]);
        tally_and_finish();
    end
endmodule
